// ===== pkg/spc_regs.svh
// register offsets, field positions and timing counts for sleep power control
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

`define SPC_IO_BIAS         8'h20
`define SPC_IO_TOP          8'h3F
`define SPC_EXT_BASE        8'h60
`define SPC_SLEEP_OFS       8'h53
`define SPC_CORE_OFS        8'h55
`define SPC_PRR_OFS         8'h64
`define SPC_SLEEP_RST       8'h00
`define SPC_CORE_RST        8'h00
`define SPC_PRR_RST         8'h00
`define SPC_SLEEP_ALLOW_BIT 0
`define SPC_SEL_LO_BIT      1
`define SPC_SEL_HI_BIT      3
`define SPC_CORE_WMASK      8'hF3
`define SPC_DBG_BIT         7
`define SPC_BOS_BIT         6
`define SPC_BOU_BIT         5
`define SPC_PUK_BIT         4
`define SPC_VTS_BIT         1
`define SPC_VCU_BIT         0
`define SPC_UNLOCK_CYC      3'd4
`define SPC_BOS_DELAY       3'd3
`define SPC_BOS_HOLD        3'd3
`define SPC_WAKE_NS         60
`define SPC_CLK_NS          10
`define SPC_WAKE_CYC        4'((`SPC_WAKE_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_NPERIPH         8

`endif

// ===== pkg/spc_pkg.sv
// types shared by the sleep power control block
package spc_pkg;
    typedef enum logic [2:0] {
        SPC_MODE_IDLE     = 3'b000,
        SPC_MODE_NOISE    = 3'b001,
        SPC_MODE_PDOWN    = 3'b010,
        SPC_MODE_PSAVE    = 3'b011,
        SPC_MODE_RSV4     = 3'b100,
        SPC_MODE_RSV5     = 3'b101,
        SPC_MODE_STANDBY  = 3'b110,
        SPC_MODE_XSTANDBY = 3'b111
    } spc_mode_t;

    typedef enum logic [1:0] {
        SPC_ST_RUN   = 2'b00,
        SPC_ST_SLEEP = 2'b01,
        SPC_ST_WAKE  = 2'b10
    } spc_state_t;
endpackage : spc_pkg

// ===== src/spc_timed_unlock.sv
// window counter: open for a fixed number of cycles after an arming event
`timescale 1ns/1ns
`default_nettype none
`include "spc_regs.svh"
module spc_timed_unlock (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic arm,
    input  wire logic consume,
    output logic      open
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (arm) begin
            cnt_d = `SPC_UNLOCK_CYC;
        end else if (consume) begin
            cnt_d = 3'h0;
        end else if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign open = (cnt_q != 3'h0);
endmodule : spc_timed_unlock
`default_nettype wire

// ===== src/spc_sync3.sv
// three-stage synchroniser; a level is taken once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module spc_sync3 (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic       out_q;
    logic       out_d;

    always_comb begin
        sh_d  = {sh_q[1:0], din};
        out_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : out_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sh_q  <= 3'h0;
            out_q <= 1'b0;
        end else begin
            sh_q  <= sh_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule : spc_sync3
`default_nettype wire

// ===== src/spc_sleep_power_control.sv
// sleep mode control, peripheral clock gating and core misc control register
//
// Functional notes
// RL1: power-save without async second timer stops its low-frequency oscillator.
// RL2: in power-save the running synchronous clock reaches only the second timer.
// RL3: select 110 with crystal option enters standby: power-down, oscillator kept.
// RL4: wake from standby resumes execution after six clock cycles.
// RL5: select 111 with crystal option enters extended standby: power-save, oscillator kept.
// RL6: wake from extended standby resumes execution after six clock cycles.
// RL7: power-reduction bit set stops peripheral clock; its register accesses are blocked.
// RL8: clearing power-reduction bit restarts clock; peripheral continues unchanged.
// RL9: gating bits act in active and idle; other sleep modes stop clocks anyway.
// RL10: converter stays enabled in sleep; re-enable makes next conversion extended.
// RL11: short I/O address equals data offset minus 0x20, range 0x00 to 0x3F.
// RL12: registers from data 0x60 upward reachable only by load and store.
// RL13: sleep control at 0x53/0x33, reset zero, bits 3:1 select, bit 0 allow.
// RL14: select decodes idle, noise reduction, power-down, power-save; 100, 101 reserved.
// RL15: sleep instruction enters sleep only while sleep allow is one.
// RL16: debug port off bit one disables scan port; zero enables it if fused.
// RL17: debug port off changes only on two equal writes within four cycles.
// RL18: brown-out sleep armed by writing both bits one, then unlock zero within four.
// RL19: brown-out sleep active three cycles after set, clears three later; sleep kills detector.
// RL20: pull-up kill forces all port pull-ups off.
// RL21: vector select zero puts vectors at memory start, one at boot section.
// RL22: core control at 0x55/0x35, reset zero, bits 7,6,5,4,1,0.
// RL23: vector select change needs change unlock first, then write within four cycles.
`timescale 1ns/1ns
`default_nettype none
`include "spc_regs.svh"
module spc_sleep_power_control (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  busAddr,
    input  wire logic        busIoSpace,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    input  wire logic [7:0]  busWdata,
    output logic      [7:0]  busRdata,
    input  wire logic        sleepInstr,
    input  wire logic        wakeEvent,
    input  wire logic        crystalOption,
    input  wire logic        timer2Async,
    input  wire logic        debugPortFuse,
    input  wire logic        bootSizeSel,
    input  wire logic        convEnable,
    output logic             cpuRun,
    output logic             sleeping,
    output logic             mainOscRun,
    output logic             lowFreqOscRun,
    output logic             brownoutOn,
    output logic [7:0]       periphClkEn,
    output logic [7:0]       periphRegBlock,
    output logic             timer2SyncClkEn,
    output logic             convExtended,
    output logic             debugPortEnable,
    output logic             pullupAllow,
    output logic             vectorAtBoot
);
    import spc_pkg::*;

    // ******************************************************
    // address decode
    // ******************************************************
    logic [7:0] dataAddr;
    logic       hitSleep;
    logic       hitCore;
    logic       hitPrr;
    logic       wrSleep;
    logic       wrCore;
    logic       wrPrr;

    always_comb begin
        dataAddr = busIoSpace ? (busAddr + `SPC_IO_BIAS) : busAddr; // RL11
        hitSleep = (dataAddr == `SPC_SLEEP_OFS) && (!busIoSpace || busAddr <= `SPC_IO_TOP);
        hitCore  = (dataAddr == `SPC_CORE_OFS) && (!busIoSpace || busAddr <= `SPC_IO_TOP);
        // extended space rejects the short I/O form outright
        hitPrr   = (dataAddr == `SPC_PRR_OFS) && !busIoSpace; // RL12
        wrSleep  = busWrite && hitSleep;
        wrCore   = busWrite && hitCore;
        wrPrr    = busWrite && hitPrr;
    end

    // ******************************************************
    // registers
    // ******************************************************
    logic [3:0] sleepCtrl_q;
    logic [3:0] sleepCtrl_d;
    logic [7:0] prr_q;
    logic [7:0] prr_d;
    logic       dbgOff_q;
    logic       dbgOff_d;
    logic       dbgPend_q;
    logic       dbgPend_d;
    logic       bosUnlock_q;
    logic       bosUnlock_d;
    logic       pullupKill_q;
    logic       pullupKill_d;
    logic       vecSel_q;
    logic       vecSel_d;
    logic       vecUnlock_q;
    logic       vecUnlock_d;
    logic [2:0] bosCnt_q;
    logic [2:0] bosCnt_d;
    logic       bosSet_d;
    logic       dbgOpen;
    logic       bosOpen;
    logic       vecOpen;
    logic       dbgArm;
    logic       bosArm;
    logic       vecArm;
    logic       bosActive;
    logic       wDbg;
    logic       wBos;
    logic       wBou;
    logic       wVts;
    logic       wVcu;

    always_comb begin
        wDbg = busWdata[`SPC_DBG_BIT];
        wBos = busWdata[`SPC_BOS_BIT];
        wBou = busWdata[`SPC_BOU_BIT];
        wVts = busWdata[`SPC_VTS_BIT];
        wVcu = busWdata[`SPC_VCU_BIT];
        sleepCtrl_d  = wrSleep ? busWdata[3:0] : sleepCtrl_q; // RL13
        prr_d        = wrPrr ? busWdata : prr_q;
        pullupKill_d = wrCore ? busWdata[`SPC_PUK_BIT] : pullupKill_q;
        // first write opens a window; a matching second write inside it commits
        dbgArm    = wrCore && (wDbg != dbgOff_q) && !(dbgOpen && dbgPend_q == wDbg);
        dbgPend_d = dbgArm ? wDbg : dbgPend_q;
        dbgOff_d  = dbgOff_q;
        if (wrCore && dbgOpen && (wDbg == dbgPend_q) && (wDbg != dbgOff_q)) begin
            dbgOff_d = wDbg; // RL17
        end
        bosArm      = wrCore && wBos && wBou;
        bosUnlock_d = wrCore ? wBou : bosUnlock_q;
        if (bosOpen && !bosArm && !wrCore) begin
            bosUnlock_d = bosUnlock_q;
        end else if (!bosOpen && !wrCore) begin
            bosUnlock_d = 1'b0;
        end
        bosSet_d = wrCore && bosOpen && wBos && !wBou; // RL18
        bosCnt_d = (bosCnt_q != 3'h0) ? bosCnt_q - 3'h1 : 3'h0;
        if (bosSet_d) begin
            bosCnt_d = `SPC_BOS_DELAY + `SPC_BOS_HOLD; // RL19
        end
        bosActive = (bosCnt_q != 3'h0) && (bosCnt_q <= `SPC_BOS_HOLD); // RL19
        vecArm      = wrCore && wVcu;
        vecUnlock_d = vecOpen && !(wrCore && !wVcu);
        if (vecArm) begin
            vecUnlock_d = 1'b1;
        end
        vecSel_d = vecSel_q;
        if (wrCore && !wVcu && vecOpen) begin
            vecSel_d = wVts; // RL23
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sleepCtrl_q  <= 4'(`SPC_SLEEP_RST);
            prr_q        <= `SPC_PRR_RST;
            dbgOff_q     <= 1'b0;
            dbgPend_q    <= 1'b0;
            bosUnlock_q  <= 1'b0;
            pullupKill_q <= 1'b0;
            vecSel_q     <= 1'b0;
            vecUnlock_q  <= 1'b0;
            bosCnt_q     <= 3'h0;
        end else begin
            sleepCtrl_q  <= sleepCtrl_d;
            prr_q        <= prr_d;
            dbgOff_q     <= dbgOff_d;
            dbgPend_q    <= dbgPend_d;
            bosUnlock_q  <= bosUnlock_d;
            pullupKill_q <= pullupKill_d;
            vecSel_q     <= vecSel_d;
            vecUnlock_q  <= vecUnlock_d;
            bosCnt_q     <= bosCnt_d;
        end
    end

    spc_timed_unlock uDbgWin (
        .clk     (clk),
        .reset   (reset),
        .arm     (dbgArm),
        .consume (dbgOff_d != dbgOff_q),
        .open    (dbgOpen)
    );

    spc_timed_unlock uBosWin (
        .clk     (clk),
        .reset   (reset),
        .arm     (bosArm),
        .consume (bosSet_d),
        .open    (bosOpen)
    );

    spc_timed_unlock uVecWin (
        .clk     (clk),
        .reset   (reset),
        .arm     (vecArm),
        .consume (wrCore && !wVcu),
        .open    (vecOpen)
    );

    // ******************************************************
    // sleep sequencer
    // ******************************************************
    logic       wakeSync;
    spc_state_t state_q;
    spc_state_t state_d;
    spc_mode_t  mode_q;
    spc_mode_t  mode_d;
    spc_mode_t  selMode;
    logic [3:0] wakeCnt_q;
    logic [3:0] wakeCnt_d;
    logic       bodOff_q;
    logic       bodOff_d;
    logic       modeOk;

    spc_sync3 uWakeSync (
        .clk   (clk),
        .reset (reset),
        .din   (wakeEvent),
        .dout  (wakeSync)
    );

    always_comb begin
        selMode = spc_mode_t'(sleepCtrl_q[`SPC_SEL_HI_BIT:`SPC_SEL_LO_BIT]);
        case (selMode) // RL14
            SPC_MODE_RSV4, SPC_MODE_RSV5: modeOk = 1'b0;
            SPC_MODE_STANDBY, SPC_MODE_XSTANDBY: modeOk = crystalOption; // RL3 RL5
            default: modeOk = 1'b1;
        endcase
        state_d   = state_q;
        mode_d    = mode_q;
        wakeCnt_d = wakeCnt_q;
        bodOff_d  = bodOff_q;
        case (state_q)
            SPC_ST_RUN: begin
                if (sleepInstr && sleepCtrl_q[`SPC_SLEEP_ALLOW_BIT] && modeOk) begin
                    state_d  = SPC_ST_SLEEP; // RL15
                    mode_d   = selMode;
                    bodOff_d = bosActive; // RL19
                end
            end
            SPC_ST_SLEEP: begin
                if (wakeSync) begin
                    state_d   = SPC_ST_WAKE;
                    wakeCnt_d = `SPC_WAKE_CYC; // RL4 RL6
                end
            end
            SPC_ST_WAKE: begin
                wakeCnt_d = wakeCnt_q - 4'h1;
                if (wakeCnt_q == 4'h1) begin
                    state_d  = SPC_ST_RUN;
                    bodOff_d = 1'b0;
                end
            end
            default: begin
                state_d = SPC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= SPC_ST_RUN;
            mode_q    <= SPC_MODE_IDLE;
            wakeCnt_q <= 4'h0;
            bodOff_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            mode_q    <= mode_d;
            wakeCnt_q <= wakeCnt_d;
            bodOff_q  <= bodOff_d;
        end
    end

    // ******************************************************
    // registered outputs
    // ******************************************************
    logic        inSleep;
    logic        idleLike;
    logic        psaveLike;
    logic        convOn_q;
    logic        convExt_d;
    logic        convExt_q;
    logic [7:0]  rd_d;
    logic [7:0]  rd_q;
    logic [7:0]  gate_d;
    logic [7:0]  gate_q;
    logic [7:0]  blk_q;
    logic [13:0] misc_d;
    logic [13:0] misc_q;

    always_comb begin
        inSleep   = (state_q != SPC_ST_RUN);
        idleLike  = !inSleep || (mode_q == SPC_MODE_IDLE);
        psaveLike = (mode_q == SPC_MODE_PSAVE) || (mode_q == SPC_MODE_XSTANDBY);
        // converter stays on while enabled; a fresh enable edge flags the long conversion
        convExt_d = (convEnable && !convOn_q) ? 1'b1 : (convExt_q && convEnable); // RL10
        rd_d = 8'h00;
        if (busRead && hitSleep) begin
            rd_d = {4'h0, sleepCtrl_q};
        end else if (busRead && hitCore) begin // RL22
            rd_d = {dbgOff_q, bosActive, bosUnlock_q, pullupKill_q, 2'b00, vecSel_q,
                    vecUnlock_q} & `SPC_CORE_WMASK;
        end else if (busRead && hitPrr) begin
            rd_d = prr_q;
        end
    end

    // one copy per peripheral: gated in active/idle by its bit, stopped in deeper modes
    genvar gi;
    generate
        for (gi = 0; gi < `SPC_NPERIPH; gi = gi + 1) begin : gPeriph
            always_comb begin
                gate_d[gi] = idleLike ? !prr_q[gi] : 1'b0; // RL7 RL8 RL9
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    gate_q[gi] <= 1'b1;
                    blk_q[gi]  <= 1'b0;
                end else begin
                    gate_q[gi] <= gate_d[gi];
                    blk_q[gi]  <= prr_q[gi]; // RL7
                end
            end
        end
    endgenerate

    always_comb begin
        // taken from the same state as the sleep flag so the two never overlap
        misc_d[0]  = !inSleep; // RL15
        misc_d[1]  = inSleep;
        misc_d[2]  = !inSleep || idleLike || (mode_q == SPC_MODE_NOISE)
                     || (mode_q == SPC_MODE_STANDBY) || (mode_q == SPC_MODE_XSTANDBY); // RL3 RL5
        misc_d[3]  = !(inSleep && psaveLike && !timer2Async) && timer2Async; // RL1
        misc_d[4]  = !bodOff_q; // RL19
        misc_d[5]  = inSleep && psaveLike ? !timer2Async : idleLike; // RL2
        misc_d[6]  = !dbgOff_q && debugPortFuse; // RL16
        misc_d[7]  = !pullupKill_q; // RL20
        misc_d[8]  = vecSel_q && bootSizeSel;
        misc_d[9]  = vecSel_q; // RL21
        misc_d[13:10] = 4'h0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            convOn_q  <= 1'b0;
            convExt_q <= 1'b0;
            rd_q      <= 8'h00;
            misc_q    <= 14'h00d5;
        end else begin
            convOn_q  <= convEnable;
            convExt_q <= convExt_d;
            rd_q      <= rd_d;
            misc_q    <= misc_d;
        end
    end

    assign busRdata        = rd_q;
    assign cpuRun          = misc_q[0];
    assign sleeping        = misc_q[1];
    assign mainOscRun      = misc_q[2];
    assign lowFreqOscRun   = misc_q[3];
    assign brownoutOn      = misc_q[4];
    assign periphClkEn     = gate_q;
    assign periphRegBlock  = blk_q;
    assign timer2SyncClkEn = misc_q[5];
    assign convExtended    = convExt_q;
    assign debugPortEnable = misc_q[6];
    assign pullupAllow     = misc_q[7];
    assign vectorAtBoot    = misc_q[9];
endmodule : spc_sleep_power_control
`default_nettype wire

// ===== verif/spc_sleep_power_control_properties.sv
// concurrent checks on the ports of the sleep power control block
`timescale 1ns/1ns
`default_nettype none
module spc_power_checker (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       busWrite,
    input wire logic       busRead,
    input wire logic [7:0] busRdata,
    input wire logic       sleepInstr,
    input wire logic       wakeEvent,
    input wire logic       timer2Async,
    input wire logic       convEnable,
    input wire logic       cpuRun,
    input wire logic       sleeping,
    input wire logic       mainOscRun,
    input wire logic       lowFreqOscRun,
    input wire logic       brownoutOn,
    input wire logic [7:0] periphClkEn,
    input wire logic [7:0] periphRegBlock,
    input wire logic       convExtended,
    input wire logic       vectorAtBoot
);
    // ****************************************
    // properties, all in the system clock domain
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_rdata_idle_zero: assert property (!$past(busRead) |-> busRdata == 8'h00)
        else $error("read data not zero outside a read");
    a_sleep_needs_instr: assert property ($rose(sleeping) |-> $past(sleepInstr) || $past(sleepInstr, 2))
        else $error("sleep entered without a sleep instruction");
    a_cpu_halted_asleep: assert property (sleeping |-> !cpuRun)
        else $error("cpu running while asleep");
    a_wake_six_cycles: assert property ($rose(cpuRun) |-> !$past(cpuRun, 6) && !$past(cpuRun, 3))
        else $error("cpu resumed in fewer than six cycles");
    a_wake_bounded: assert property (sleeping && $rose(wakeEvent) |-> ##[1:14] cpuRun)
        else $error("cpu did not resume after wake event");
    a_osc_stops_asleep: assert property (!mainOscRun |-> sleeping || !cpuRun)
        else $error("main oscillator stopped while running");
    a_lfo_stopped_sync: assert property (sleeping && !timer2Async && !$past(timer2Async) |-> !lowFreqOscRun)
        else $error("low frequency oscillator running without async timer");
    a_brownout_asleep_only: assert property (!brownoutOn |-> sleeping || !cpuRun)
        else $error("brown-out detector off while running");
    // compared against a two-cycle-old copy so a one-cycle skew between the outputs is tolerated
    a_gate_block_match: assert property (cpuRun && !sleeping && periphClkEn == $past(periphClkEn, 2)
        |-> periphRegBlock == ~periphClkEn)
        else $error("register block disagrees with clock gating");
    a_conv_extended_rise: assert property ($rose(convEnable) |-> ##[1:2] convExtended)
        else $error("re-enabled converter not flagged extended");
    a_vector_needs_write: assert property ($changed(vectorAtBoot) |-> $past(busWrite) || $past(busWrite, 2))
        else $error("vector placement changed without a write");

    c_sleep_entered: cover property ($rose(sleeping));
    c_brownout_off: cover property ($fell(brownoutOn));
    c_vector_boot: cover property ($rose(vectorAtBoot));
endmodule // spc_power_checker

bind spc_sleep_power_control spc_power_checker i_spc_power_checker (
    .clk(clk), .reset(reset), .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
    .sleepInstr(sleepInstr), .wakeEvent(wakeEvent), .timer2Async(timer2Async),
    .convEnable(convEnable), .cpuRun(cpuRun), .sleeping(sleeping), .mainOscRun(mainOscRun),
    .lowFreqOscRun(lowFreqOscRun), .brownoutOn(brownoutOn), .periphClkEn(periphClkEn),
    .periphRegBlock(periphRegBlock), .convExtended(convExtended), .vectorAtBoot(vectorAtBoot)
);
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the sleep power control block
`timescale 1ns/1ns
`default_nettype none
`include "spc_regs.svh"
module testbench;
    import spc_pkg::*;
    localparam logic [7:0] SLP = `SPC_SLEEP_OFS;
    localparam logic [7:0] CORE = `SPC_CORE_OFS;
    localparam logic [7:0] POWER_REDUCTION_REG = `SPC_PRR_OFS;
    logic       clk = 1'b0, reset = 1'b1, busIoSpace = 1'b0, busWrite = 1'b0, busRead = 1'b0;
    logic [7:0] busAddr = 8'h00, busWdata = 8'h00, busRdata, periphClkEn, periphRegBlock;
    logic       sleepInstr = 1'b0, wakeEvent = 1'b0, crystalOption = 1'b0, convEnable = 1'b0;
    logic       timer2Async = 1'b0, debugPortFuse = 1'b1, bootSizeSel = 1'b0;
    logic       cpuRun, sleeping, mainOscRun, lowFreqOscRun, brownoutOn, timer2SyncClkEn;
    logic       convExtended, debugPortEnable, pullupAllow, vectorAtBoot;
    int         nErrors = 0, checksDone = 0;

    spc_sleep_power_control i_spc_sleep_power_control (
        .clk(clk), .reset(reset), .busAddr(busAddr), .busIoSpace(busIoSpace),
        .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
        .sleepInstr(sleepInstr), .wakeEvent(wakeEvent), .crystalOption(crystalOption),
        .timer2Async(timer2Async), .debugPortFuse(debugPortFuse), .bootSizeSel(bootSizeSel),
        .convEnable(convEnable), .cpuRun(cpuRun), .sleeping(sleeping), .mainOscRun(mainOscRun),
        .lowFreqOscRun(lowFreqOscRun), .brownoutOn(brownoutOn), .periphClkEn(periphClkEn),
        .periphRegBlock(periphRegBlock), .timer2SyncClkEn(timer2SyncClkEn),
        .convExtended(convExtended), .debugPortEnable(debugPortEnable),
        .pullupAllow(pullupAllow), .vectorAtBoot(vectorAtBoot)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // ****************************************
    // bus and comparison tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // entered and left just after a rising edge, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
        busAddr <= a;
        busIoSpace <= io;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge clk);
        busWrite <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdck(input logic [7:0] a, input logic io, input logic [7:0] exp);
        busAddr <= a;
        busIoSpace <= io;
        busRead <= 1'b1;
        @(posedge clk);
        busRead <= 1'b0;
        #1 check(busRdata, exp);
        @(posedge clk);
    endtask

    task automatic doSleep();
        sleepInstr <= 1'b1;
        @(posedge clk);
        sleepInstr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // wake is held until the cpu runs, then dropped and left to drain through the synchroniser
    task automatic doWake();
        int k;
        k = 0;
        @(posedge clk);
        wakeEvent <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check(cpuRun, 1'b0);
        while (cpuRun !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1 k++;
        end
        check(cpuRun, 1'b1);
        @(posedge clk);
        wakeEvent <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic stopTest();
        $display("checks %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        nErrors++;
        stopTest();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        spc_mode_t md;
        logic      ok;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(periphClkEn, 8'hFF);
        check(debugPortEnable, 1'b1);
        check(pullupAllow, 1'b1);
        @(posedge clk);
        rdck(SLP, 1'b0, `SPC_SLEEP_RST);
        rdck(CORE, 1'b0, `SPC_CORE_RST);
        rdck(POWER_REDUCTION_REG, 1'b0, `SPC_PRR_RST);
        wr(SLP - `SPC_IO_BIAS, 1'b1, 8'hFF);
        rdck(SLP, 1'b0, 8'h0F);
        rdck(CORE - `SPC_IO_BIAS, 1'b1, 8'h00);
        wr(CORE - `SPC_IO_BIAS, 1'b1, 8'h10);
        #1 check(pullupAllow, 1'b0);
        @(posedge clk);
        rdck(CORE, 1'b0, 8'h10);
        wr(POWER_REDUCTION_REG - `SPC_IO_BIAS, 1'b1, 8'h5A);
        rdck(POWER_REDUCTION_REG, 1'b0, 8'h00);
        rdck(POWER_REDUCTION_REG - `SPC_IO_BIAS, 1'b1, 8'h00);
        wr(POWER_REDUCTION_REG, 1'b0, 8'hA5);
        #1 check(periphClkEn, 8'h5A);
        check(periphRegBlock, 8'hA5);
        @(posedge clk);
        rdck(POWER_REDUCTION_REG, 1'b0, 8'hA5);
        wr(POWER_REDUCTION_REG, 1'b0, 8'h0F);
        #1 check(periphClkEn, 8'hF0);
        @(posedge clk);
        $display("test registers finished");

        wr(SLP, 1'b0, 8'h00);
        doSleep();
        check(sleeping, 1'b0);
        @(posedge clk);
        for (int x = 0; x < 2; x++) begin
            for (int m = 0; m < 8; m++) begin
                md = spc_mode_t'(m);
                ok = !(md == SPC_MODE_RSV4 || md == SPC_MODE_RSV5) && (m < 6 || x == 1);
                crystalOption <= x[0];
                timer2Async <= x[0];
                wr(SLP, 1'b0, {4'h0, 3'(m), 1'b1});
                doSleep();
                check(sleeping, ok);
                if (ok && m >= 6) check(mainOscRun, 1'b1);
                if (md == SPC_MODE_PDOWN) check(mainOscRun, 1'b0);
                if (md == SPC_MODE_PSAVE) check(lowFreqOscRun, x[0]);
                if (md == SPC_MODE_PSAVE) check(timer2SyncClkEn, !x[0]);
                if (md == SPC_MODE_PSAVE) check(periphClkEn, 8'h00);
                if (md == SPC_MODE_IDLE) check(periphClkEn, 8'hF0);
                if (md == SPC_MODE_PDOWN) check(periphClkEn, 8'h00);
                if (ok) doWake();
                else @(posedge clk);
            end
        end
        $display("test sleep modes finished");

        wr(SLP, 1'b0, 8'h05);
        wr(CORE, 1'b0, 8'h40);
        doSleep();
        check(brownoutOn, 1'b1);
        doWake();
        wr(CORE, 1'b0, 8'h60);
        wr(CORE, 1'b0, 8'h40);
        repeat (2) @(posedge clk);
        doSleep();
        check(brownoutOn, 1'b0);
        doWake();
        rdck(CORE, 1'b0, 8'h00);
        $display("test brown-out finished");

        wr(CORE, 1'b0, 8'h02);
        #1 check(vectorAtBoot, 1'b0);
        repeat (6) @(posedge clk);
        wr(CORE, 1'b0, 8'h01);
        wr(CORE, 1'b0, 8'h02);
        #1 check(vectorAtBoot, 1'b1);
        @(posedge clk);
        rdck(CORE, 1'b0, 8'h02);
        wr(CORE, 1'b0, 8'h82);
        repeat (6) @(posedge clk);
        #1 check(debugPortEnable, 1'b1);
        @(posedge clk);
        wr(CORE, 1'b0, 8'h82);
        wr(CORE, 1'b0, 8'h82);
        @(posedge clk);
        #1 check(debugPortEnable, 1'b0);
        @(posedge clk);
        rdck(CORE, 1'b0, 8'h82);
        $display("test core control finished");

        convEnable <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(convExtended, 1'b1);
        @(posedge clk);
        convEnable <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(convExtended, 1'b0);
        $display("test converter finished");
        stopTest();
    end
endmodule // testbench
`default_nettype wire
